/* dsto_pkg.sv */
// Package for the dual channel torque-off interlock: timing counts and encodings.
// Assumes a 25 MHz core clock; all counts derive from it.
package dsto_pkg;
  localparam int unsigned CLK_HZ = 25000000;
  // Pulse tolerance on a channel input, in microseconds
  localparam int unsigned PULSE_TOL_US = 1000;
  // Allowed skew between the two channels, in milliseconds
  localparam int unsigned SKEW_MS = 200;
  // Glitch filter length: least time, rounded up
  localparam int unsigned PULSE_TOL_CYC = (PULSE_TOL_US * (CLK_HZ / 1000000) + 1);
  // Skew window length: longest time, rounded down
  localparam int unsigned SKEW_CYC = SKEW_MS * (CLK_HZ / 1000);
  localparam int unsigned FILT_W = 16;
  localparam int unsigned SKEW_W = 23;
  // Indication select encodings
  localparam logic [1:0] SEL_FAULT_FAULT = 2'h0;
  localparam logic [1:0] SEL_FAULT_WARN = 2'h1;
  localparam logic [1:0] SEL_WARN_WARN = 2'h2;
  localparam logic [1:0] SEL_NONE_NONE = 2'h3;
  typedef enum logic [1:0] {
    DSTO_STOPPED = 2'b00,
    DSTO_RUNNING = 2'b01,
    DSTO_LOCKED = 2'b10
  } dsto_state_type;
endpackage : dsto_pkg

/* dsto_chan_filter.sv */
// One channel input: three-flop synchroniser and pulse filter.
// Assumes the raw input is asynchronous to clk.
`timescale 1ns/1ns
module dsto_chan_filter
  import dsto_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic raw_in,
  output logic level_q
);
  logic s1_q, s2_q, s3_q;
  logic [FILT_W-1:0] cnt_q;

  // Synchroniser; s1 is read only by s2
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
    end else begin
      s1_q <= raw_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // Level only accepted once stable longer than the pulse tolerance
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cnt_q <= '0;
      level_q <= 1'b0;
    end else if (s2_q != s3_q || s3_q == level_q) begin
      cnt_q <= '0; // Restart on any change or when settled
    end else if (cnt_q >= FILT_W'(PULSE_TOL_CYC)) begin
      level_q <= s3_q;
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_q + 1'b1;
    end
  end
endmodule : dsto_chan_filter

/* dsto_interlock.sv */
// Dual channel torque-off interlock: gates output-stage enable from two channels.
// Assumes channel inputs are asynchronous pins, high when energised; commands are clk-synchronous.
`timescale 1ns/1ns
module dsto_interlock
  import dsto_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic channel_a_input,
  input wire logic channel_b_input,
  input wire logic start_cmd,
  input wire logic stop_cmd,
  input wire logic fault_reset,
  input wire logic [1:0] loss_indication_select,
  output logic [5:0] gate_enable_q,
  output logic running_q,
  output logic safe_torque_off_q,
  output logic fault_q,
  output logic warning_q,
  output logic start_refused_q
);
  // Filtered channel levels and their disagreement timer
  logic [1:0] chan_raw;
  logic [1:0] chan_lvl;
  logic chan_a, chan_b;
  logic chan_differ;
  logic [SKEW_W-1:0] skew_q;
  logic skew_full;

  // Loss decode and indication choice
  logic single_loss;
  logic any_loss;
  logic both_ok;
  logic loss_q;
  logic loss_edge;
  logic ind_fault, ind_warn;
  logic fault_set;

  // Run control
  logic refuse_now;
  logic run_ok;
  dsto_state_type state_q, state_d;

  // Channel pins gathered so both pass identical filters
  assign chan_raw = {channel_b_input, channel_a_input};

  // Per channel synchroniser and pulse filter
  for (genvar g = 0; g < 2; g++) begin : g_chan
    dsto_chan_filter i_dsto_chan_filter (
      .clk(clk),
      .rstn(rstn),
      .raw_in(chan_raw[g]),
      .level_q(chan_lvl[g])
    );
  end

  // Filtered levels, high while the channel is energised
  assign chan_a = chan_lvl[0];
  assign chan_b = chan_lvl[1];
  assign chan_differ = chan_a != chan_b;

  // Disagreement timer; a mismatch inside the skew window is still a normal switch action
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      skew_q <= '0;
    end else if (!chan_differ) begin
      skew_q <= '0;
    end else if (!skew_full) begin
      skew_q <= skew_q + 1'b1; // Saturates so a long mismatch stays flagged
    end
  end

  // Mismatch outlasting the skew window is taken as a wiring or hardware fault
  assign skew_full = skew_q == SKEW_W'(SKEW_CYC);
  assign single_loss = chan_differ && skew_full;

  // Loss decode
  assign any_loss = !chan_a || !chan_b;
  assign both_ok = chan_a && chan_b;
  assign loss_edge = any_loss && !loss_q;

  // Start asked for while a channel is down and the drive is idle
  assign refuse_now = start_cmd && (state_q != DSTO_RUNNING) && !both_ok;

  // Drive may conduct this cycle; stop and loss act without waiting for the state
  assign run_ok = (state_q == DSTO_RUNNING) && !any_loss && !stop_cmd;

  // Loss history for the edge detector; resets to lost so no false edge follows reset
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      loss_q <= 1'b1;
    end else begin
      loss_q <= any_loss;
    end
  end

  // Torque-off request follows any dropped channel at once
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      safe_torque_off_q <= 1'b1;
    end else begin
      safe_torque_off_q <= any_loss;
    end
  end

  // Indication choice; reaches the run logic only through fault_q blocking a start
  always_comb begin
    ind_fault = 1'b0;
    ind_warn = 1'b0;
    case (loss_indication_select)
      SEL_FAULT_FAULT: ind_fault = 1'b1;
      SEL_FAULT_WARN: begin
        ind_fault = (state_q == DSTO_RUNNING);
        ind_warn = (state_q != DSTO_RUNNING);
      end
      SEL_WARN_WARN: ind_warn = 1'b1;
      SEL_NONE_NONE: ; // Reporting off; stopping still acts
      default: ;
    endcase
  end

  // A loss edge raises a fault when the select asks for one, a single loss always does
  assign fault_set = single_loss || (loss_edge && ind_fault);

  // Sticky fault; a new cause wins over the reset in the same cycle
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      fault_q <= 1'b0;
    end else if (fault_set) begin
      fault_q <= 1'b1;
    end else if (fault_reset) begin
      fault_q <= 1'b0;
    end
  end

  // One pulse per refused start cycle
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      start_refused_q <= 1'b0;
    end else begin
      start_refused_q <= refuse_now;
    end
  end

  // Warning follows the loss while selected, or a refused start
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      warning_q <= 1'b0;
    end else if (refuse_now) begin
      warning_q <= 1'b1;
    end else if (loss_edge && ind_warn) begin
      warning_q <= 1'b1;
    end else if (both_ok) begin
      warning_q <= 1'b0; // Cleared once both channels are back
    end
  end

  // Next state; LOCKED waits for channels back and faults cleared
  always_comb begin
    state_d = state_q;
    case (state_q)
      DSTO_RUNNING: begin
        if (any_loss) begin
          state_d = DSTO_LOCKED;
        end else if (stop_cmd) begin
          state_d = DSTO_STOPPED;
        end
      end
      DSTO_STOPPED: begin
        if (any_loss) begin
          state_d = DSTO_LOCKED;
        end else if (start_cmd && !fault_q) begin
          state_d = DSTO_RUNNING;
        end
      end
      DSTO_LOCKED: begin
        // Level start held through restoration is not a fresh command
        if (both_ok && !fault_q && !start_cmd) begin
          state_d = DSTO_STOPPED;
        end
      end
      default: state_d = DSTO_LOCKED;
    endcase
  end

  // Run state register; reset lands in LOCKED so a start needs restored channels first
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_q <= DSTO_LOCKED;
    end else begin
      state_q <= state_d;
    end
  end

  // Run flag mirrors the gates so status matches the power stage
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      running_q <= 1'b0;
    end else begin
      running_q <= run_ok;
    end
  end

  // Gate enables drop the same edge a loss is seen, not a cycle later
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      gate_enable_q <= '0;
    end else begin
      gate_enable_q <= {6{run_ok}};
    end
  end
endmodule : dsto_interlock

/* dsto_switch_model.sv */
// Activation switch model driving both channel pins.
// Assumes requests change at the falling edge of clk.
`timescale 1ns/1ns
module dsto_switch_model (
  input wire logic clk,
  input wire logic close_req,
  input wire logic glitch_a,
  output logic channel_a = 1'b0,
  output logic channel_b = 1'b0
);
  // One contact feeds both pins on the same edge; only glitch_a makes them differ
  always @(posedge clk) begin
    channel_a <= close_req & ~glitch_a;
    channel_b <= close_req;
  end
endmodule : dsto_switch_model

/* dsto_interlock_chk.sv */
// Checker on the interlock outputs.
// Assumes it is bound to every dsto_interlock instance.
`timescale 1ns/1ns
module dsto_interlock_chk (
  input wire logic clk,
  input wire logic rstn,
  input wire logic channel_a_input,
  input wire logic channel_b_input,
  input wire logic start_cmd,
  input wire logic stop_cmd,
  input wire logic fault_reset,
  input wire logic [1:0] loss_indication_select,
  input wire logic [5:0] gate_enable_q,
  input wire logic running_q,
  input wire logic safe_torque_off_q,
  input wire logic fault_q,
  input wire logic warning_q,
  input wire logic start_refused_q
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  chk_off_gates: assert property (safe_torque_off_q |-> gate_enable_q == 6'h00)
    else $error("gates on in torque-off");
  chk_all_gates: assert property (gate_enable_q == 6'h00 || gate_enable_q == 6'h3F)
    else $error("partial gate enable");
  chk_loss_stops: assert property (safe_torque_off_q |-> !running_q)
    else $error("running in torque-off");
  chk_start_cause: assert property ($rose(running_q) |-> $past(start_cmd, 2))
    else $error("run without start");
  chk_fault_block: assert property ($rose(running_q) |-> !$past(fault_q, 2))
    else $error("start with fault");
  chk_stop_drop: assert property (stop_cmd && running_q |=> gate_enable_q == 6'h00)
    else $error("stop ignored");
  chk_refuse_cause: assert property (start_refused_q |-> $past(start_cmd))
    else $error("refusal without start");
  chk_refuse_warn: assert property (start_refused_q |-> ##[0:1] warning_q)
    else $error("refusal without warning");
  chk_fault_cause: assert property ($rose(fault_q) |-> safe_torque_off_q)
    else $error("fault without channel loss");
endmodule : dsto_interlock_chk
bind dsto_interlock dsto_interlock_chk i_chk (.*);

/* dsto_interlock_bench.sv */
// Bench: switch model on the channels, queued expectations on run/stop.
// Assumes package, design, model and checker are compiled first.
`timescale 1ns/1ns
module dsto_interlock_bench;
  logic clk = 1'b0, rstn = 1'b0, close_req = 1'b0, glitch_a = 1'b0;
  logic start_cmd = 1'b0, stop_cmd = 1'b0, fault_reset = 1'b0;
  logic [1:0] sel = 2'h0;
  logic chan_a, chan_b, running_q, off_q, refused_q, fault_q, warn_q;
  logic [5:0] gates;
  logic [4:0] exp_q[$];
  logic [4:0] note_w;
  logic exp_fault = 1'b0, exp_warn = 1'b0;
  int fails = 0, tests_run = 0, cycles = 0, seed = 62244, len;
  always #20 clk = ~clk;
  dsto_switch_model i_dsto_switch_model (.clk(clk), .close_req(close_req), .glitch_a(glitch_a),
    .channel_a(chan_a), .channel_b(chan_b));
  dsto_interlock i_dsto_interlock (.clk(clk), .rstn(rstn), .channel_a_input(chan_a), .channel_b_input(chan_b),
    .start_cmd(start_cmd), .stop_cmd(stop_cmd), .fault_reset(fault_reset), .loss_indication_select(sel),
    .gate_enable_q(gates), .running_q(running_q), .safe_torque_off_q(off_q), .fault_q(fault_q), .warning_q(warn_q),
    .start_refused_q(refused_q));
  task automatic summarize;
    $display("Comparisons %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : summarize
  task automatic check(input logic [7:0] seen, input logic [7:0] want);
    tests_run++;
    if (seen !== want) begin
      fails++;
      $display("Error t=%0t seen %h expected %h", $time, seen, want);
    end
  endtask : check
  // Note lands after an edge; the watcher compares half a cycle later
  task automatic note(input logic [4:0] want);
    @(posedge clk);
    exp_q.push_back(want);
    @(negedge clk);
  endtask : note
  task automatic wait_cyc(input int n);
    repeat (n) @(negedge clk);
  endtask : wait_cyc
  task automatic pulse(ref logic sig);
    sig = 1'b1;
    @(negedge clk);
    sig = 1'b0;
    wait_cyc(2);
  endtask : pulse
  // Watcher: oldest note against run, torque-off, refusal, fault, warning, and every gate
  always @(negedge clk) begin
    if (exp_q.size() > 0) begin
      note_w = exp_q.pop_front();
      check({3'h0, running_q, off_q, refused_q, fault_q, warn_q}, {3'h0, note_w});
      check({2'h0, gates}, {2'h0, {6{note_w[4]}}});
    end
  end
  // Hang guard, well above the ~85k cycles used
  always @(posedge clk) begin
    cycles++;
    if (cycles == 100000) begin
      fails++;
      summarize();
    end
  end
  initial begin
    wait_cyc(12);
    rstn = 1'b1;
    note(5'h08);
    start_cmd = 1'b1;
    note(5'h0D);
    start_cmd = 1'b0;
    close_req = 1'b1;
    wait_cyc(25010);
    note(5'h00);
    pulse(fault_reset);
    pulse(start_cmd);
    note(5'h10);
    sel = 2'($random(seed));
    len = 1000 + ($random(seed) & 8191);
    glitch_a = 1'b1;
    wait_cyc(len);
    glitch_a = 1'b0;
    wait_cyc(100);
    note(5'h10);
    pulse(stop_cmd);
    note(5'h00);
    pulse(start_cmd);
    sel = 2'($random(seed));
    // Loss while running: the select alone decides fault or warning
    exp_fault = (sel == dsto_pkg::SEL_FAULT_FAULT) || (sel == dsto_pkg::SEL_FAULT_WARN);
    exp_warn = (sel == dsto_pkg::SEL_WARN_WARN);
    glitch_a = 1'b1;
    wait_cyc(25010);
    note({3'h2, exp_fault, exp_warn});
    glitch_a = 1'b0;
    wait_cyc(25010);
    note({3'h0, exp_fault, 1'h0});
    pulse(start_cmd);
    note({!exp_fault, 2'h0, exp_fault, 1'h0});
    pulse(fault_reset);
    pulse(start_cmd);
    note(5'h10);
    wait_cyc(1);
    summarize();
  end
endmodule : dsto_interlock_bench
